// >>> verilog/arc_ref_ctrl.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module arc_ref_ctrl (
  // Clock and reset.
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  // Register port.
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Factory offset value loaded from trim storage.
  input  wire logic [9:0] temp_offset_i,
  // Converter status.
  input  wire logic       temp_channel_i,
  input  wire logic       tracking_i,
  input  wire logic       converting_i,
  // Analog controls.
  output logic      [3:0] vref_sel_onehot_o,
  output logic            gnd_pin_sel_o,
  output logic            analog_ground_pin_sel_o,
  output logic            gnd_internal_sel_o,
  output logic            hs_ref_power_o,
  output logic            temp_sensor_enable_o
);

  arc_cfg_if cfg ();

  logic [3:0]        vref_onehot;
  arc_pkg::arc_gnd_e gnd_sel;
  logic              hs_ref_power;
  logic              temp_en;

  // Register file.
  arc_regs u_regs (
    .ref_clk_i     (ref_clk_i),
    .resetn_i      (resetn_i),
    .addr_i        (addr_i),
    .wdata_i       (wdata_i),
    .wr_i          (wr_i),
    .rd_i          (rd_i),
    .rdata_o       (rdata_o),
    .temp_offset_i (temp_offset_i),
    .cfg           (cfg)
  );

  // Reference and ground decode.
  arc_mux u_mux (
    .cfg            (cfg),
    .temp_channel_i (temp_channel_i),
    .tracking_i     (tracking_i),
    .converting_i   (converting_i),
    .vref_onehot    (vref_onehot),
    .gnd_sel        (gnd_sel),
    .hs_ref_power   (hs_ref_power),
    .temp_en        (temp_en)
  );

  // Registered analog controls; one cycle after a setting or phase change.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      vref_sel_onehot_o       <= 4'h0_008;
      gnd_pin_sel_o           <= 1'b1;
      analog_ground_pin_sel_o <= 1'b0;
      gnd_internal_sel_o      <= 1'b0;
      hs_ref_power_o          <= 1'b0;
      temp_sensor_enable_o    <= 1'b0;
    end else begin
      vref_sel_onehot_o       <= vref_onehot;
      gnd_pin_sel_o           <= gnd_sel == arc_pkg::ARC_GND_PIN;
      analog_ground_pin_sel_o <= gnd_sel == arc_pkg::ARC_GND_ANALOG_PIN;
      gnd_internal_sel_o      <= gnd_sel == arc_pkg::ARC_GND_INTERNAL;
      hs_ref_power_o          <= hs_ref_power;
      temp_sensor_enable_o    <= temp_en;
    end
  end

  AST_HS_OFF_IDLE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !tracking_i && !converting_i |=> !hs_ref_power_o) else $error("Fast ref on while idle.");
  AST_HS_ON: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    converting_i && vref_onehot[3] |=> hs_ref_power_o) else $error("Fast ref off in use.");
  AST_TEMP_GND: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    tracking_i && !converting_i && temp_channel_i |=> gnd_internal_sel_o)
    else $error("Sensor sample not on internal ground.");
  AST_CONV_GND: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    converting_i && vref_onehot[3] |=> gnd_internal_sel_o && !analog_ground_pin_sel_o)
    else $error("Fast ref conversion not on internal ground.");
  AST_WRITE_TAKES: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_i && addr_i == arc_pkg::ADDR_REFERENCE_CTRL ##1 !(wr_i && addr_i == arc_pkg::ADDR_REFERENCE_CTRL)
    |=> temp_sensor_enable_o == $past(wdata_i[2], 2)) else $error("Sensor enable not updated.");
  AST_ONEHOT: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $onehot(vref_sel_onehot_o)) else $error("Reference select not one-hot.");
  AST_GND_ONE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $onehot({gnd_pin_sel_o, analog_ground_pin_sel_o, gnd_internal_sel_o}))
    else $error("Ground select not one-hot.");

endmodule : arc_ref_ctrl

// >>> pkg/arc_pkg.sv
package arc_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] ADDR_TEMP_OFFSET_LOW  = 8'h00_BD;
  localparam logic [7:0] ADDR_TEMP_OFFSET_HIGH = 8'h00_BE;
  localparam logic [7:0] ADDR_REFERENCE_CTRL   = 8'h00_D1;

  // Reference control field positions and reset value.
  localparam int          GND_SEL_BIT      = 5;
  localparam int          VREF_SEL_MSB     = 4;
  localparam int          VREF_SEL_LSB     = 3;
  localparam int          TEMP_EN_BIT      = 2;
  localparam logic [7:0]  REF_CTRL_RESET   = 8'h00_18;
  localparam logic [7:0]  REF_CTRL_WMASK   = 8'h00_3C;

  // Factory offset layout.
  localparam int          TEMP_OFFSET_WIDTH       = 10;
  localparam int          TEMP_OFFSET_LOW_BITS    = 2;
  localparam int          TEMP_OFFSET_LOW_POS     = 6;

  // Voltage reference selections.
  localparam logic [1:0]  VREF_EXT_PIN     = 2'h0;
  localparam logic [1:0]  VREF_SUPPLY_PIN  = 2'h1;
  localparam logic [1:0]  VREF_DIG_SUPPLY  = 2'h2;
  localparam logic [1:0]  VREF_HS_INTERNAL = 2'h3;

  // Ground reference selections driven to the analog mux.
  typedef enum logic [1:0] {
    ARC_GND_PIN,
    ARC_GND_ANALOG_PIN,
    ARC_GND_INTERNAL
  } arc_gnd_e;

  // Converter phase as seen by the reference logic.
  typedef enum logic [1:0] {
    ARC_PH_IDLE,
    ARC_PH_TRACK,
    ARC_PH_CONVERT
  } arc_phase_e;

endpackage : arc_pkg

// >>> pkg/arc_cfg_if.sv
`timescale 1ns/1ps
// Decoded reference settings passed from the register file to the mux logic.
interface arc_cfg_if;
  logic [1:0] vref_select;
  logic       ground_ref_select;
  logic       temp_sensor_enable;

  modport regs (output vref_select, output ground_ref_select, output temp_sensor_enable);
  modport mux  (input vref_select, input ground_ref_select, input temp_sensor_enable);
endinterface : arc_cfg_if

// >>> verilog/arc_regs.sv
`timescale 1ns/1ps
// Register file: reference control plus read-only factory offset.
module arc_regs (
  // Clock and reset.
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  // Register port.
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Factory offset value.
  input  wire logic [9:0] temp_offset_i,
  // Settings to the mux logic.
  arc_cfg_if.regs         cfg
);

  logic [7:0] ref_ctrl_r;
  logic [7:0] rdata_nxt;

  // Writes keep only the defined fields; unused bits stay zero.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ref_ctrl_r <= arc_pkg::REF_CTRL_RESET;
    end else if (wr_i && addr_i == arc_pkg::ADDR_REFERENCE_CTRL) begin
      ref_ctrl_r <= wdata_i & arc_pkg::REF_CTRL_WMASK;
    end
  end

  // Read data mux; unmapped addresses return zero.
  always_comb begin
    rdata_nxt = 8'h00_00;
    case (addr_i)
      arc_pkg::ADDR_TEMP_OFFSET_HIGH: rdata_nxt = temp_offset_i[9:2];
      arc_pkg::ADDR_TEMP_OFFSET_LOW:  rdata_nxt = {temp_offset_i[1:0], 6'h00};
      arc_pkg::ADDR_REFERENCE_CTRL:   rdata_nxt = ref_ctrl_r & arc_pkg::REF_CTRL_WMASK;
      default:                        rdata_nxt = 8'h00_00;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00_00;
    end else if (rd_i) begin
      rdata_o <= rdata_nxt;
    end else begin
      rdata_o <= 8'h00_00;
    end
  end

  // Fields go straight from the stored register.
  assign cfg.vref_select        = ref_ctrl_r[arc_pkg::VREF_SEL_MSB:arc_pkg::VREF_SEL_LSB];
  assign cfg.ground_ref_select  = ref_ctrl_r[arc_pkg::GND_SEL_BIT];
  assign cfg.temp_sensor_enable = ref_ctrl_r[arc_pkg::TEMP_EN_BIT];

  AST_UNUSED_ZERO: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (ref_ctrl_r & ~arc_pkg::REF_CTRL_WMASK) == 8'h00_00) else $error("Unused bits set.");
  AST_LOW_READ: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_i && addr_i == arc_pkg::ADDR_TEMP_OFFSET_LOW |=> rdata_o[5:0] == 6'h00)
    else $error("Low offset unused bits nonzero.");
  AST_HIGH_READ: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_i && addr_i == arc_pkg::ADDR_TEMP_OFFSET_HIGH |=> rdata_o == $past(temp_offset_i[9:2]))
    else $error("High offset read wrong.");

endmodule : arc_regs

// >>> verilog/arc_mux.sv
`timescale 1ns/1ps
// Reference decode: picks voltage reference, ground reference and powers the fast reference.
module arc_mux (
  // Settings.
  arc_cfg_if.mux              cfg,
  // Converter state.
  input  wire logic           temp_channel_i,
  input  wire logic           tracking_i,
  input  wire logic           converting_i,
  // Decoded controls.
  output logic [3:0]          vref_onehot,
  output arc_pkg::arc_gnd_e   gnd_sel,
  output logic                hs_ref_power,
  output logic                temp_en
);

  // One-hot reference decode, shared by the mux and the power logic.
  function automatic logic [3:0] vref_decode(input logic [1:0] sel);
    vref_decode = 4'h0_001 << sel;
  endfunction : vref_decode

  arc_pkg::arc_phase_e phase;

  // Phase of the converter.
  always_comb begin
    if (converting_i) begin
      phase = arc_pkg::ARC_PH_CONVERT;
    end else if (tracking_i) begin
      phase = arc_pkg::ARC_PH_TRACK;
    end else begin
      phase = arc_pkg::ARC_PH_IDLE;
    end
  end

  // Reference select decode.
  assign vref_onehot = vref_decode(cfg.vref_select);

  // Fast reference runs only while the converter tracks or converts.
  // A function result cannot be bit-selected, so the shared one-hot net is read instead.
  assign hs_ref_power = vref_onehot[arc_pkg::VREF_HS_INTERNAL]
                        && phase != arc_pkg::ARC_PH_IDLE;

  // Ground choice, with internal-ground overrides taking priority.
  always_comb begin
    case (phase)
      arc_pkg::ARC_PH_TRACK: begin
        if (temp_channel_i) begin
          gnd_sel = arc_pkg::ARC_GND_INTERNAL;
        end else begin
          gnd_sel = cfg.ground_ref_select ? arc_pkg::ARC_GND_ANALOG_PIN
                                          : arc_pkg::ARC_GND_PIN;
        end
      end
      arc_pkg::ARC_PH_CONVERT: begin
        if (cfg.vref_select == arc_pkg::VREF_HS_INTERNAL) begin
          gnd_sel = arc_pkg::ARC_GND_INTERNAL;
        end else begin
          gnd_sel = cfg.ground_ref_select ? arc_pkg::ARC_GND_ANALOG_PIN
                                          : arc_pkg::ARC_GND_PIN;
        end
      end
      default: begin
        gnd_sel = cfg.ground_ref_select ? arc_pkg::ARC_GND_ANALOG_PIN
                                        : arc_pkg::ARC_GND_PIN;
      end
    endcase
  end

  assign temp_en = cfg.temp_sensor_enable;

endmodule : arc_mux

// >>> testbench/arc_conv_model.sv
`timescale 1ns/1ps
// Converter model: tracks, then converts, for the lengths that the bench asks for.
module arc_conv_model (
  // Clock.
  input  wire logic       ref_clk_i,
  // Conversion request.
  input  wire logic       start_i,
  input  wire logic       temp_i,
  input  wire logic [3:0] trk_len_i,
  input  wire logic [3:0] cnv_len_i,
  // Converter status.
  output logic            temp_channel_o,
  output logic            tracking_o,
  output logic            converting_o,
  output logic            busy_o
);
  logic [3:0] trk_r  = 4'h0;
  logic [3:0] cnv_r  = 4'h0;
  logic       temp_r = 1'b0;

  // A request is taken only while idle, so a phase is never cut short.
  always_ff @(posedge ref_clk_i) begin
    if (start_i && !busy_o) begin
      trk_r  <= trk_len_i;
      cnv_r  <= cnv_len_i;
      temp_r <= temp_i;
    end else if (trk_r != 4'h0) begin
      trk_r <= trk_r - 4'h1;
    end else if (cnv_r != 4'h0) begin
      cnv_r <= cnv_r - 4'h1;
    end
  end

  // The channel stays where software left it between conversions.
  assign temp_channel_o = temp_r;
  assign tracking_o     = trk_r != 4'h0;
  assign converting_o   = trk_r == 4'h0 && cnv_r != 4'h0;
  assign busy_o         = tracking_o | converting_o;
endmodule : arc_conv_model

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
  // Stimulus, status and observed outputs.
  logic       ref_clk_i = 1'b0;
  logic       resetn_i  = 1'b0;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  logic       start     = 1'b0;
  logic       temp_ch   = 1'b0;
  logic [7:0] addr_i    = 8'h00_00;
  logic [7:0] wdata_i   = 8'h00_00;
  logic [3:0] trk_len   = 4'h1;
  logic [3:0] cnv_len   = 4'h1;
  logic [9:0] temp_offset_i;
  logic [7:0] rdata_o, sh, sh_d, exp_rd;
  logic [3:0] vref_sel_onehot_o;
  logic [2:0] ph_d;
  logic       temp_channel_i, tracking_i, converting_i, busy, hs_ref_power_o;
  logic       gnd_pin_sel_o, analog_ground_pin_sel_o, gnd_internal_sel_o, temp_sensor_enable_o;
  int         mismatches = 0;
  int         tests_run  = 0;
  int         live       = 0;

  always #25 ref_clk_i = ~ref_clk_i;

  arc_ref_ctrl u_dut (.ref_clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .temp_offset_i, .temp_channel_i, .tracking_i, .converting_i, .vref_sel_onehot_o,
    .gnd_pin_sel_o, .analog_ground_pin_sel_o, .gnd_internal_sel_o, .hs_ref_power_o,
    .temp_sensor_enable_o);
  arc_conv_model u_conv (.ref_clk_i, .start_i(start), .temp_i(temp_ch), .trk_len_i(trk_len),
    .cnv_len_i(cnv_len), .temp_channel_o(temp_channel_i), .tracking_o(tracking_i),
    .converting_o(converting_i), .busy_o(busy));

  // Read value of a register for a given control content.
  function automatic logic [7:0] rd_val(input logic [7:0] a, input logic [7:0] r);
    case (a)
      arc_pkg::ADDR_TEMP_OFFSET_LOW:  return {temp_offset_i[1:0], 6'h00};
      arc_pkg::ADDR_TEMP_OFFSET_HIGH: return temp_offset_i[9:2];
      arc_pkg::ADDR_REFERENCE_CTRL:   return r;
      default:                        return 8'h00_00;
    endcase
  endfunction : rd_val

  // Ground selection as {analog pin, internal, ground pin}; phase is {temp, track, conv}.
  function automatic logic [2:0] exp_gnd(input logic [7:0] r, input logic [2:0] ph);
    if (ph[0] ? (r[4:3] == 2'h3) : (ph[1] & ph[2])) return 3'h2;
    return r[5] ? 3'h4 : 3'h1;
  endfunction : exp_gnd

  // Compares one value and reports a mismatch.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // One bus cycle; strobes stay up so that cycles may follow with no gap.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= w;
    rd_i    <= !w;
    @(posedge ref_clk_i);
  endtask : bus

  // Releases both strobes for one cycle.
  task automatic idle();
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : idle

  // Runs one conversion and waits, bounded, until the converter is idle.
  task automatic conv(input logic t, input logic [3:0] tl, input logic [3:0] cl);
    int n;
    wr_i    <= 1'b0;
    rd_i    <= 1'b0;
    temp_ch <= t;
    trk_len <= tl;
    cnv_len <= cl;
    start   <= 1'b1;
    @(posedge ref_clk_i);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (busy === 1'b1 && n < 40);
    if (n >= 40) begin
      mismatches++;
      wrap_up();
    end
  endtask : conv

  // Shadow of the control register and the causes seen in the previous cycle.
  always @(posedge ref_clk_i) begin
    ph_d   <= {temp_channel_i, tracking_i, converting_i};
    sh_d   <= sh;
    exp_rd <= rd_i ? rd_val(addr_i, sh) : 8'h00_00;
    live   <= resetn_i ? live + 1 : 0;
    if (!resetn_i) begin
      sh <= arc_pkg::REF_CTRL_RESET;
    end else if (wr_i && addr_i == arc_pkg::ADDR_REFERENCE_CTRL) begin
      sh <= wdata_i & arc_pkg::REF_CTRL_WMASK;
    end
  end

  // Every output is compared in mid-cycle, once settled.
  always @(negedge ref_clk_i) begin
    if (live >= 2) begin
      chk("rdata", exp_rd, rdata_o);
      chk("vref", {4'h0, 4'h1 << sh_d[4:3]}, {4'h0, vref_sel_onehot_o});
      chk("temp_en", {7'h00, sh_d[2]}, {7'h00, temp_sensor_enable_o});
      chk("hs_pwr", {7'h00, sh_d[4:3] == 2'h3 && ph_d[1:0] != 2'h0},
          {7'h00, hs_ref_power_o});
      chk("gnd", {5'h00, exp_gnd(sh_d, ph_d)},
          {5'h00, analog_ground_pin_sel_o, gnd_internal_sel_o, gnd_pin_sel_o});
    end
  end

  initial begin
    logic [7:0] d;
    void'($urandom(10));
    temp_offset_i = 10'($urandom);
    repeat (5) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    bus(1'b0, arc_pkg::ADDR_REFERENCE_CTRL, 8'h00_00);
    // Every select, ground and enable setting, with junk in the unused bits.
    for (int i = 0; i < 16; i++) begin
      d = (8'($urandom) & 8'h00_C3) | {2'h0, i[3:0], 2'h0};
      bus(1'b1, arc_pkg::ADDR_REFERENCE_CTRL, d);
      bus(1'b0, arc_pkg::ADDR_REFERENCE_CTRL, 8'h00_00);
      bus(1'b1, arc_pkg::ADDR_TEMP_OFFSET_LOW, 8'h00_FF);
      bus(1'b1, arc_pkg::ADDR_TEMP_OFFSET_HIGH, 8'h00_A5);
      bus(1'b0, arc_pkg::ADDR_TEMP_OFFSET_LOW, 8'h00_00);
      bus(1'b0, arc_pkg::ADDR_TEMP_OFFSET_HIGH, 8'h00_00);
      bus(1'b0, 8'h00_C0, 8'h00_00);
      idle();
      conv(d[2], 4'(1 + i % 2), 4'(1 + $urandom % 4));
    end
    // Random traffic mixing register cycles and conversions.
    for (int i = 0; i < 300; i++) begin
      case ($urandom % 4)
        0: bus(1'b1, arc_pkg::ADDR_REFERENCE_CTRL, 8'($urandom));
        1: bus(1'b0, 8'h00_BD + 8'($urandom % 3), 8'h00_00);
        2: conv(1'($urandom), 4'(1 + $urandom % 8), 4'(1 + $urandom % 8));
        default: idle();
      endcase
    end
    // A second reset in mid-run restores the control register.
    idle();
    resetn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    bus(1'b0, arc_pkg::ADDR_REFERENCE_CTRL, 8'h00_00);
    idle();
    idle();
    wrap_up();
  end
endmodule : tb
